// *** hw/spimc_map.vh ***
// register offsets, field positions, reset values and the bits-per-byte count of the serial engine
// assumes: included by the engine files; APB byte addresses, one register per word
`ifndef SPIMC_MAP_VH
`define SPIMC_MAP_VH
`define SPIMC_OFF_CTRL1      8'h00
`define SPIMC_OFF_CTRL2      8'h04
`define SPIMC_OFF_IRQEN      8'h08
`define SPIMC_OFF_FLAGS      8'h0C
`define SPIMC_OFF_DATA       8'h10
`define SPIMC_OFF_PINCFG     8'h14
// control_first fields
`define SPIMC_C1_ENABLE      0
`define SPIMC_C1_PRESC_LO    1
`define SPIMC_C1_CLK2X       4
`define SPIMC_C1_HOST        5
`define SPIMC_C1_ORDER       6
// control_second fields
`define SPIMC_C2_MODE_LO     0
`define SPIMC_C2_SELDIS      2
`define SPIMC_C2_RXWAIT      6
`define SPIMC_C2_BUFON       7
// irq_enable_register fields
`define SPIMC_IE_DONE        0
`define SPIMC_IE_TXC         6
// flag_register fields
`define SPIMC_FL_TXE         5
`define SPIMC_FL_COLL_TXC    6
`define SPIMC_FL_DONE        7
// pin direction fields
`define SPIMC_PC_MOSI_OE     0
`define SPIMC_PC_MISO_OE     1
`define SPIMC_PC_SCK_OE      2
`define SPIMC_PC_SEL_OE      3
`define SPIMC_RESET_BYTE     8'h00
`define SPIMC_BITS_PER_BYTE  4'h8
`endif

// *** hw/spimc_sync.v ***
// two-flop synchroniser for the serial pins
// assumes: inputs are asynchronous to clk
`timescale 1ns/10ps
module spimc_sync (
    clk,
    resetn,
    din,
    dout
);
    parameter       INIT = 1'b1;
    input  wire     clk;
    input  wire     resetn;
    input  wire     din;
    output wire     dout;

    reg             meta_r;
    reg             sync_r;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule // spimc_sync

// *** hw/spimc_core.v ***
// serial peripheral engine: master or slave byte transfers with APB registers
// assumes: pins are asynchronous and pass two flops; APB on clk; one clock domain
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "spimc_map.vh"
module spimc_core (
    clk,
    resetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    sck_i,
    sck_o,
    sck_oe,
    mosi_i,
    mosi_o,
    mosi_oe,
    miso_i,
    miso_o,
    miso_oe,
    sel_n_i,
    sel_n_o,
    sel_n_oe,
    irq
);
    input  wire        clk;
    input  wire        resetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [7:0]  paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output wire        pready;
    output wire        pslverr;
    input  wire        sck_i;
    output reg         sck_o;
    output wire        sck_oe;
    input  wire        mosi_i;
    output reg         mosi_o;
    output wire        mosi_oe;
    input  wire        miso_i;
    output reg         miso_o;
    output wire        miso_oe;
    input  wire        sel_n_i;
    output wire        sel_n_o;
    output wire        sel_n_oe;
    output wire        irq;

    // ************************************************************
    // register bus
    // ************************************************************
    reg  [7:0] ctrl1_r;
    reg  [7:0] ctrl2_r;
    reg  [7:0] irqen_r;
    reg  [3:0] pincfg_r;
    reg        done_r;
    reg        coll_r;
    reg        txc_r;
    reg        txe_r;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire hit_data = (paddr == `SPIMC_OFF_DATA);
    wire data_wr = wr_en & hit_data;
    wire data_rd = rd_en & hit_data;
    wire flags_rd = rd_en & (paddr == `SPIMC_OFF_FLAGS);

    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `SPIMC_OFF_CTRL1) | (a == `SPIMC_OFF_CTRL2) |
                         (a == `SPIMC_OFF_IRQEN) | (a == `SPIMC_OFF_FLAGS) |
                         (a == `SPIMC_OFF_DATA)  | (a == `SPIMC_OFF_PINCFG);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);

    wire       enable  = ctrl1_r[`SPIMC_C1_ENABLE];
    wire       host    = ctrl1_r[`SPIMC_C1_HOST];
    wire       lsb_1st = ctrl1_r[`SPIMC_C1_ORDER];
    wire [1:0] presc   = ctrl1_r[`SPIMC_C1_PRESC_LO+1:`SPIMC_C1_PRESC_LO];
    wire       clk2x   = ctrl1_r[`SPIMC_C1_CLK2X];
    wire       cpha    = ctrl2_r[`SPIMC_C2_MODE_LO];
    wire       cpol    = ctrl2_r[`SPIMC_C2_MODE_LO+1];
    wire       seldis  = ctrl2_r[`SPIMC_C2_SELDIS];
    wire       bufon   = ctrl2_r[`SPIMC_C2_BUFON];

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire sck_s;
    wire mosi_s;
    wire miso_s;
    wire sel_s;
    spimc_sync #(.INIT(1'b0)) u_sck  (.clk(clk), .resetn(resetn), .din(sck_i),   .dout(sck_s));
    spimc_sync #(.INIT(1'b0)) u_mosi (.clk(clk), .resetn(resetn), .din(mosi_i),  .dout(mosi_s));
    spimc_sync #(.INIT(1'b0)) u_miso (.clk(clk), .resetn(resetn), .din(miso_i),  .dout(miso_s));
    spimc_sync #(.INIT(1'b1)) u_sel  (.clk(clk), .resetn(resetn), .din(sel_n_i), .dout(sel_s));

    // ************************************************************
    // shift engine state
    // ************************************************************
    reg  [7:0] shift_r;
    reg  [7:0] txbuf_r;
    reg        txfull_r;
    reg  [3:0] bitcnt_r;
    reg        busy_r;
    reg        phase_r;
    reg  [6:0] div_r;
    reg  [7:0] rx0_r;
    reg  [7:0] rx1_r;
    reg  [1:0] rxcnt_r;
    reg        sck_d_r;
    reg        in_bit_r;

    // contention only when select is an input and not disabled; output select keeps mastership
    wire contend = enable & host & ~seldis & ~pincfg_r[`SPIMC_PC_SEL_OE] & ~sel_s;
    wire slave_act = enable & ~host & ~sel_s;

    // half period in clk cycles from prescaler and doubling
    reg  [6:0] half_lim;
    always @* begin
        case (presc)
            2'b00:   half_lim = 7'h02;
            2'b01:   half_lim = 7'h08;
            2'b10:   half_lim = 7'h20;
            default: half_lim = 7'h40;
        endcase
        if (clk2x) begin
            half_lim = {1'b0, half_lim[6:1]};
        end
    end
    wire tick = (div_r == half_lim - 7'h01);

    // slave clock edges seen on the synchronised pin
    wire s_rise = sck_s & ~sck_d_r;
    wire s_fall = ~sck_s & sck_d_r;
    wire s_lead = cpol ? s_fall : s_rise;
    wire s_trail = cpol ? s_rise : s_fall;
    // sample on leading edge for phase 0, trailing for phase 1; shift on the other
    wire s_sample = slave_act & (cpha ? s_trail : s_lead);
    wire s_shift  = slave_act & (cpha ? s_lead : s_trail);
    wire cur_bit_out = lsb_1st ? shift_r[0] : shift_r[7];

    function [7:0] shift_in;
        input [7:0] v;
        input       b;
        input       lsb;
        begin
            shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
        end
    endfunction

    wire m_start = enable & host & ~busy_r & ~contend &
                   ((data_wr & ~bufon) | (bufon & txfull_r));
    wire m_tick  = busy_r & host & tick;
    // a master bit period: first half samples, second half shifts (phase 0)
    wire m_sample = m_tick & (phase_r == cpha);
    wire m_shift  = m_tick & (phase_r != cpha);
    wire m_last   = m_tick & phase_r & (bitcnt_r == `SPIMC_BITS_PER_BYTE - 4'h1);
    wire s_last   = s_sample & (bitcnt_r == `SPIMC_BITS_PER_BYTE - 4'h1);
    wire byte_end = m_last | s_last;
    wire sbusy    = slave_act & (bitcnt_r != 4'h0);
    wire busy_any = busy_r | sbusy;
    wire rx_full2 = (rxcnt_r == 2'd2);

    // ************************************************************
    // shifting, clocking and buffering
    // ************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_r  <= `SPIMC_RESET_BYTE;
            txbuf_r  <= `SPIMC_RESET_BYTE;
            txfull_r <= 1'b0;
            bitcnt_r <= 4'h0;
            busy_r   <= 1'b0;
            phase_r  <= 1'b0;
            div_r    <= 7'h00;
            sck_o    <= 1'b0;
            mosi_o   <= 1'b0;
            miso_o   <= 1'b0;
            rx0_r    <= `SPIMC_RESET_BYTE;
            rx1_r    <= `SPIMC_RESET_BYTE;
            rxcnt_r  <= 2'd0;
            sck_d_r  <= 1'b0;
            in_bit_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
            div_r   <= (busy_r & ~tick) ? div_r + 7'h01 : 7'h00;
            if (!busy_r) begin
                sck_o <= cpol;
            end
            // transmit buffer fills only while empty; later writes are lost
            if (data_wr && bufon && !txfull_r) begin
                txbuf_r  <= pwdata[7:0];
                txfull_r <= 1'b1;
            end
            if (m_start) begin
                busy_r   <= 1'b1;
                phase_r  <= 1'b0;
                bitcnt_r <= 4'h0;
                if (bufon) begin
                    shift_r  <= txbuf_r;
                    txfull_r <= 1'b0;
                    mosi_o   <= lsb_1st ? txbuf_r[0] : txbuf_r[7];
                end else begin
                    shift_r <= pwdata[7:0];
                    mosi_o  <= lsb_1st ? pwdata[0] : pwdata[7];
                end
            end else if (busy_r && (!host || contend)) begin
                busy_r   <= 1'b0;
                bitcnt_r <= 4'h0;
            end else if (m_tick) begin
                sck_o   <= ~sck_o;
                phase_r <= ~phase_r;
                if (m_sample) begin
                    in_bit_r <= miso_s;
                end
                if (m_shift || (m_tick && phase_r)) begin
                    if (phase_r) begin
                        shift_r  <= shift_in(shift_r, cpha ? miso_s : in_bit_r, lsb_1st);
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                if (m_tick && phase_r && !m_last) begin
                    mosi_o <= lsb_1st ? shift_r[1] : shift_r[6];
                end
                if (m_last) begin
                    busy_r   <= 1'b0;
                    bitcnt_r <= 4'h0;
                end
            end else if (!host) begin
                if (!enable || sel_s) begin
                    bitcnt_r <= 4'h0;
                    miso_o   <= cur_bit_out;
                    if (bufon && txfull_r) begin
                        shift_r  <= txbuf_r;
                        txfull_r <= 1'b0;
                    end
                end else begin
                    if (s_sample) begin
                        shift_r  <= shift_in(shift_r, mosi_s, lsb_1st);
                        bitcnt_r <= s_last ? 4'h0 : bitcnt_r + 4'h1;
                        if (s_last && bufon && txfull_r) begin
                            shift_r  <= txbuf_r;
                            txfull_r <= 1'b0;
                        end
                    end
                    // miso moves on the shift edge only, byte boundary included,
                    // so the far master never sees it change while it samples
                    if (s_shift) begin
                        miso_o <= cur_bit_out;
                    end
                end
            end
            // data write in unbuffered role: master busy corrupts shifter, slave keeps it
            if (data_wr && !bufon && !m_start) begin
                if (host && busy_r) begin
                    shift_r <= pwdata[7:0];
                end else if (!host && !sbusy) begin
                    shift_r <= pwdata[7:0];
                end
            end
            // receive side
            if (byte_end) begin
                if (!bufon) begin
                    rx0_r <= m_last ? shift_in(shift_r, cpha ? miso_s : in_bit_r, lsb_1st)
                                    : shift_in(shift_r, mosi_s, lsb_1st);
                end else if (!rx_full2 || data_rd) begin
                    if (rxcnt_r == 2'd0 || (rxcnt_r == 2'd1 && data_rd)) begin
                        rx0_r <= m_last ? shift_in(shift_r, cpha ? miso_s : in_bit_r, lsb_1st)
                                        : shift_in(shift_r, mosi_s, lsb_1st);
                        rxcnt_r <= 2'd1;
                    end else begin
                        if (data_rd) begin
                            rx0_r <= rx1_r;
                        end
                        rx1_r <= m_last ? shift_in(shift_r, cpha ? miso_s : in_bit_r, lsb_1st)
                                        : shift_in(shift_r, mosi_s, lsb_1st);
                        rxcnt_r <= 2'd2;
                    end
                end
            end else if (data_rd && bufon && rxcnt_r != 2'd0) begin
                rx0_r   <= rx1_r;
                rxcnt_r <= rxcnt_r - 2'd1;
            end
        end
    end

    // ************************************************************
    // control registers and flags
    // ************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl1_r  <= `SPIMC_RESET_BYTE;
            ctrl2_r  <= `SPIMC_RESET_BYTE;
            irqen_r  <= `SPIMC_RESET_BYTE;
            pincfg_r <= 4'h0;
            done_r   <= 1'b0;
            coll_r   <= 1'b0;
            txc_r    <= 1'b0;
            txe_r    <= 1'b1;
        end else begin
            if (wr_en && paddr == `SPIMC_OFF_CTRL1) begin
                ctrl1_r <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end
            if (wr_en && paddr == `SPIMC_OFF_CTRL2) begin
                ctrl2_r <= {pwdata[7:6], 3'b000, pwdata[2:0]};
            end
            if (wr_en && paddr == `SPIMC_OFF_IRQEN) begin
                irqen_r <= pwdata[7:0];
            end
            if (wr_en && paddr == `SPIMC_OFF_PINCFG) begin
                pincfg_r <= pwdata[3:0];
            end
            // done and collision/txc flags clear by writing one (txe does not); a same-cycle hardware set wins
            if (wr_en && paddr == `SPIMC_OFF_FLAGS) begin
                if (pwdata[`SPIMC_FL_DONE]) done_r <= 1'b0;
                if (pwdata[`SPIMC_FL_COLL_TXC]) begin
                    coll_r <= 1'b0;
                    txc_r  <= 1'b0;
                end
            end
            if (contend) begin
                ctrl1_r[`SPIMC_C1_HOST] <= 1'b0;
                done_r <= 1'b1;
            end
            if (byte_end) begin
                done_r <= 1'b1;
            end
            if (data_wr && !bufon && busy_any && !m_start) begin
                coll_r <= 1'b1;
            end
            if (data_wr && bufon) begin
                txe_r <= 1'b0;
            end
            if (bufon && txfull_r && (m_start || byte_end || (!host && sel_s))) begin
                txe_r <= 1'b1;
            end
            if (bufon && byte_end && !txfull_r) begin
                txc_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // read mux and pins
    // ************************************************************
    always @* begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `SPIMC_OFF_CTRL1:  prdata = {24'h00_0000, ctrl1_r};
                `SPIMC_OFF_CTRL2:  prdata = {24'h00_0000, ctrl2_r};
                `SPIMC_OFF_IRQEN:  prdata = {24'h00_0000, irqen_r};
                `SPIMC_OFF_FLAGS:  prdata = {24'h00_0000, done_r,
                                             bufon ? txc_r : coll_r, txe_r, 5'h00};
                `SPIMC_OFF_DATA:   prdata = {24'h00_0000, rx0_r};
                `SPIMC_OFF_PINCFG: prdata = {28'h000_0000, pincfg_r};
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end

    wire irq_done = done_r & irqen_r[`SPIMC_IE_DONE];
    wire irq_txc  = bufon & txc_r & irqen_r[`SPIMC_IE_TXC];
    assign irq = irq_done | irq_txc;

    // slave role forces select, data in and clock to inputs
    wire master_pins = enable & host;
    assign sck_oe   = master_pins & pincfg_r[`SPIMC_PC_SCK_OE];
    assign mosi_oe  = master_pins & pincfg_r[`SPIMC_PC_MOSI_OE];
    assign sel_n_oe = master_pins & pincfg_r[`SPIMC_PC_SEL_OE];
    assign sel_n_o  = 1'b0;
    assign miso_oe  = enable & ~host & ~sel_s & pincfg_r[`SPIMC_PC_MISO_OE];
endmodule // spimc_core

// *** verif/spimc_core_properties.sv ***
// checker: apb answers and pin relations of the serial engine
// assumes: bound into spimc_core; one clock domain
`timescale 1ns/10ps
module spimc_props (
    input wire        clk,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        sck_o,
    input wire        sck_oe,
    input wire        mosi_oe,
    input wire        miso_oe,
    input wire        sel_n_i,
    input wire        sel_n_oe
);
    wire acc = psel & penable;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ****************************************
    // properties
    // ****************************************
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= 8'h14))
        else $error("pslverr wrong");
    a_bus_quiet: assert property (!acc |-> !pslverr && prdata == 32'h0)
        else $error("bus outputs not quiet");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_slave_inputs: assert property (miso_oe |-> !sck_oe && !mosi_oe && !sel_n_oe)
        else $error("slave drives an input pin");
    a_miso_released: assert property (sel_n_i [*4] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_host_restore: assert property ($rose(sck_oe) |-> $past(acc && pwrite))
        else $error("master role came back without a write");
    a_sck_steady: assert property ($past(miso_oe) && miso_oe |-> $stable(sck_o))
        else $error("clock pin moved in slave role");
endmodule // spimc_props

bind spimc_core spimc_props u_props (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .sel_n_i(sel_n_i), .sel_n_oe(sel_n_oe));

// *** verif/spimc_peer.sv ***
// partner: byte-wide serial slave on the engine's master pins, clock mode 0
// assumes: select and reply byte come from the bench; msb first on the wire
`timescale 1ns/10ps
module spimc_peer (
    input  wire       sel_n,
    input  wire       sck,
    input  wire       mosi,
    input  wire [7:0] tx,
    output reg        miso,
    output reg  [7:0] rx,
    output integer    n_rx
);
    reg [7:0] sh;
    integer   bits;
    // ****************************************
    // shifting
    // ****************************************
    initial begin
        {miso, rx, sh} = 17'h0;
        n_rx = 0;
        bits = 0;
    end
    // reply adds the byte count, so successive bytes differ and order shows
    always @(negedge sel_n) begin
        sh = tx + n_rx[7:0];
        bits = 0;
        miso = sh[7];
    end
    // a released line shows the inverse of its last value
    always @(posedge sel_n) miso = ~miso;
    always @(posedge sck) if (!sel_n) begin
        sh = {sh[6:0], mosi};
        bits = bits + 1;
        if (bits == 8) begin
            rx = sh;
            bits = 0;
            n_rx = n_rx + 1;
            sh = tx + n_rx[7:0];
        end
    end
    always @(negedge sck) if (!sel_n) miso = sh[7];
endmodule // spimc_peer

// *** verif/spi_master_slave_transfer_core_test.sv ***
// bench: apb master, far master and far slave around the engine, model in queues
// assumes: spimc_core, spimc_peer, spimc_props compiled first; map header on path
`timescale 1ns/10ps
`include "spimc_map.vh"
module spi_master_slave_transfer_core_test;
    localparam logic [7:0] R_C1 = `SPIMC_OFF_CTRL1, R_C2 = `SPIMC_OFF_CTRL2;
    localparam logic [7:0] R_EN = `SPIMC_OFF_IRQEN, R_FL = `SPIMC_OFF_FLAGS;
    localparam logic [7:0] R_DT = `SPIMC_OFF_DATA, R_PC = `SPIMC_OFF_PINCFG;
    logic        clk, resetn, psel, penable, pwrite, e, sck_d, mosi_d, sel_d, p_sel;
    logic [7:0]  paddr, ptx, b, got, exp_q[$], got_q[$];
    logic [31:0] pwdata, q;
    wire  [31:0] prdata;
    wire         pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire         sel_n_o, sel_n_oe, irq, p_miso;
    wire  [7:0]  p_rx;
    integer      p_n, n_fail, total_checks, k, o;
    // whoever enables a pin drives its wire
    wire sck_w = sck_oe ? sck_o : sck_d;
    wire mosi_w = mosi_oe ? mosi_o : mosi_d;
    wire miso_w = miso_oe ? miso_o : p_miso;
    wire sel_w = sel_n_oe ? sel_n_o : sel_d;
    spimc_core DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .sel_n_i(sel_w), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe), .irq(irq));
    spimc_peer u_peer (.sel_n(p_sel), .sck(sck_w), .mosi(mosi_w), .tx(ptx), .miso(p_miso),
        .rx(p_rx), .n_rx(p_n));
    always #25 clk = ~clk;
    always @(p_n) if (p_n > 0) got_q.push_back(p_rx);
    // ****************************************
    // tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        rdy = 1'b0;
        for (int n = 0; n < 16 && !rdy; n++) begin
            @(posedge clk);
            rdy = (pready === 1'b1);
            {q, e} = {prdata, pslverr};
        end
        if (!rdy) n_fail++;
        {psel, penable} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_flag(input integer f);
        q = 32'h0;
        for (int n = 0; n < 400 && q[f] !== 1'b1; n++) rd(R_FL);
        if (q[f] !== 1'b1) n_fail++;
    endtask
    // far master: 400 ns clock, four clocks per phase
    task slave_byte(input logic [7:0] m, input integer nb);
        for (int i = 0; i < nb; i++) begin
            {mosi_d, sck_d} <= {m[7 - i], 1'b0};
            repeat (4) @(posedge clk);
            sck_d <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk) got = {got[6:0], miso_w};
            @(posedge clk);
        end
        {mosi_d, sck_d} <= {~mosi_d, 1'b0};
    endtask
    function automatic logic [7:0] rev(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {clk, resetn, psel, penable, pwrite, e, sck_d, mosi_d, sel_d, p_sel} = 10'h3;
        {paddr, ptx, b, got, pwdata} = 64'h0;
        {n_fail, total_checks} = 64'h0;
        void'($urandom(32'hBB25));
        repeat (20) @(posedge clk);
        {resetn, p_sel} <= 2'b10;
        rd(R_FL);
        chk("flags_reset", q, 32'h20);
        wr(8'h18, 32'hFF);
        rd(8'h18);
        chk("unmapped", {q[30:0], e}, 32'h1);
        wr(R_PC, 32'h05);
        wr(R_EN, 32'h01);
        for (o = 0; o < 2; o++) begin
            {ptx, b} = 16'($urandom);
            // a select pulse makes the far slave load its reply from the new byte
            p_sel <= 1'b1;
            @(posedge clk) p_sel <= 1'b0;
            wr(R_C1, 32'h25 | 32'(o << 6));
            rd(R_C1);
            chk("host_bit", 32'(q[5]), 32'h1);
            exp_q.push_back(o ? rev(b) : b);
            k = p_n;
            wr(R_DT, {24'h0, b});
            wait_flag(7);
            chk("peer_byte", 32'(got_q.pop_front()), 32'(exp_q.pop_front()));
            rd(R_DT);
            b = ptx + 8'(k);
            chk("master_rx", q, 32'(o ? rev(b) : b));
            @(negedge clk) chk("irq_done", {irq, sck_o}, 32'h2);
            wr(R_FL, 32'hC0);
            @(negedge clk) chk("irq_clear", 32'(irq), 32'h0);
        end
        wr(R_C1, 32'h25);
        wr(R_C2, 32'hC0);
        wr(R_EN, 32'h40);
        k = p_n;
        for (o = 0; o < 2; o++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            wait_flag(5);
            wr(R_DT, {24'h0, b});
        end
        rd(R_FL);
        chk("txe_low", 32'(q[5]), 32'h0);
        wait_flag(6);
        @(negedge clk) chk("irq_txc", 32'(irq), 32'h1);
        for (o = 0; o < 2; o++) begin
            chk("peer_buf", 32'(got_q.pop_front()), 32'(exp_q.pop_front()));
            rd(R_DT);
            b = ptx + 8'(k + o);
            chk("fifo_order", q, 32'(b));
        end
        wr(R_C2, 32'h0);
        wr(R_FL, 32'hC0);
        wr(R_DT, 32'h3C);
        wr(R_DT, 32'hC3);
        wait_flag(7);
        chk("collision", 32'(q[6]), 32'h1);
        for (o = 0; o < 3; o++) begin
            wr(R_C2, 32'(o == 1) << 2);
            wr(R_PC, 32'h05 | (32'(o == 2) << 3));
            wr(R_C1, 32'h25);
            wr(R_FL, 32'hC0);
            sel_d <= 1'b0;
            repeat (4) @(posedge clk);
            rd(R_C1);
            chk("host_kept", 32'(q[5]), 32'(o != 0));
            rd(R_FL);
            chk("contend_done", 32'(q[7]), 32'(o == 0));
            sel_d <= 1'b1;
        end
        wr(R_C1, 32'h01);
        wr(R_PC, 32'h02);
        p_sel <= 1'b1;
        {ptx, b} = 16'($urandom);
        wr(R_FL, 32'hC0);
        wr(R_DT, {24'h0, b});
        slave_byte(8'hA5, 8);
        rd(R_FL);
        chk("deselected", 32'(q[7]), 32'h0);
        for (o = 0; o < 3; o++) begin
            sel_d <= 1'b0;
            repeat (8) @(posedge clk);
            slave_byte(ptx ^ 8'(o * 8'h3C), o == 1 ? 4 : 8);
            if (o == 1) begin
                wr(R_DT, 32'h5A);
                rd(R_FL);
                chk("slave_coll", 32'(q[6]), 32'h1);
            end
            sel_d <= 1'b1;
            repeat (8) @(posedge clk);
            if (o == 0) chk("slave_miso", 32'(got), 32'(b));
            rd(R_FL);
            chk("slave_done", 32'(q[7]), 32'(o != 1));
            rd(R_DT);
            if (o != 1) chk("slave_rx", q, 32'(ptx ^ 8'(o * 8'h3C)));
            wr(R_FL, 32'hC0);
        end
        complete_run;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule // spi_master_slave_transfer_core_test
